/* core/jbci_defines.svh */
// Constants for the test access port bypass, clamp and identification logic.
// Functional notes
// - Bypass routes data in to out via one bit.
// - Capture-DR under bypass loads bypass bit zero.
// - Clamp holds outputs at boundary register values.
// - Clamp selects the one-bit bypass path.
// - Test reset pin resets TAP, selects identification.
// - Five clocks of mode select high reset.
// - Identification bit zero always reads one.
// - Shift-DR straight after reset gives one first.
// - Bypass register exists but is not default.
// - Identification shifts 32 bits, LSB first.
// - Maker code bits 11:1, part bits 27:12.
// - Revision code sits in bits 31:28.
// - Capture-IR loads pattern ending in 01.
// - Six-bit instruction, effective only at Update-IR.
// - Codes: bypass 111111, clamp 111110, ident 000010.
`ifndef JBCI_DEFINES_SVH
`define JBCI_DEFINES_SVH
`define JBCI_IR_W 6
`define JBCI_ID_W 32
`define JBCI_OP_IDCODE 6'h02
`define JBCI_OP_CLAMP 6'h3e
`define JBCI_OP_BYPASS 6'h3f
`define JBCI_CAPTURE_IR_PATTERN 6'h2d
`define JBCI_ID_LSB 1'h1
`define JBCI_BYPASS_CAPTURE 1'h0
`define JBCI_TMS_RESET_CNT 3'h5
`endif

/* core/jbci_pkg.sv */
// Types for the test access port bypass, clamp and identification logic.
package jbci_pkg;
   typedef enum logic [3:0] {
      JBCI_RESET = 4'h0, JBCI_IDLE = 4'h1, JBCI_SEL_DR = 4'h2, JBCI_CAP_DR = 4'h3,
      JBCI_SHIFT_DR = 4'h4, JBCI_EXIT1_DR = 4'h5, JBCI_PAUSE_DR = 4'h6,
      JBCI_EXIT2_DR = 4'h7, JBCI_UPD_DR = 4'h8, JBCI_SEL_IR = 4'h9,
      JBCI_CAP_IR = 4'ha, JBCI_SHIFT_IR = 4'hb, JBCI_EXIT1_IR = 4'hc,
      JBCI_PAUSE_IR = 4'hd, JBCI_EXIT2_IR = 4'he, JBCI_UPD_IR = 4'hf
   } jbci_state_e;
endpackage

/* core/jbci_tap.sv */
// Test access port with bypass, clamp and identification data registers.
`timescale 1ns/1ps
`include "jbci_defines.svh"
module jbci_tap #(
   parameter logic [10:0] MAKER_CODE = 11'h155,  // Arbitrary value.
   parameter logic [15:0] PART_CODE = 16'h1234,  // Arbitrary value.
   parameter logic [3:0] REVISION = 4'h0,        // Arbitrary value.
   parameter int BSR_W = 8
) (
   input wire logic CLK_SYS,                  // System clock, 50 MHz.
   input wire logic RST_B,                    // Asynchronous reset, active low.
   input wire logic TCK,                      // Test clock pin.
   input wire logic TMS,                      // Test mode select pin.
   input wire logic TDI,                      // Test data in pin.
   input wire logic TRST_B,                   // Test reset pin, active low.
   input wire logic [BSR_W-1:0] BSR_HOLD,     // Boundary register latched values.
   input wire logic [BSR_W-1:0] CORE_OUT,     // Functional output values.
   output logic [BSR_W-1:0] PIN_OUT,          // Values driven to the pins.
   output logic CLAMP_ACTIVE,                 // Clamp is the current instruction.
   output logic TDO,                          // Test data out pin value.
   output logic TDO_OE                        // Test data out enable, high drives.
);
   // The test clock is only sampled, so each of its phases must last at least
   // four system clocks; a faster tester would have edges merged or lost.
   // Three-stage pin samplers: two stages settle, the third gives edges.
   logic [2:0] tck_s;  // Test clock sampler.
   logic [2:0] tms_s;  // Mode select sampler.
   logic [2:0] tdi_s;  // Data in sampler.
   logic [2:0] trst_s;  // Test reset sampler.
   // Edge and level strobes in the system clock domain.
   logic tck_rise;  // One-cycle pulse on a test clock rise.
   logic tck_fall;  // One-cycle pulse on a test clock fall.
   logic trst_low;  // Test reset pin is asserted.
   jbci_pkg::jbci_state_e state, next_state;
   logic [`JBCI_IR_W-1:0] ir_shift;  // Instruction shift stage.
   logic [`JBCI_IR_W-1:0] ir;  // Current instruction.
   logic [`JBCI_ID_W-1:0] id_shift;
   logic bypass_bit;  // The single bypass stage.
   logic shift_out;  // Serial source before the output flop.
   logic tms_bit;  // Settled mode select.
   logic [2:0] tms_high_cnt;
   logic sel_id;  // Identification register selected.
   logic sel_bypass;  // Bypass register selected.
   logic sel_clamp;  // Clamp is the current instruction.

   // Pins are asynchronous; two stages before use, the third gives edges.
   // Mode select and data in reset high, the level their pins idle at.
   always_ff @(posedge CLK_SYS or negedge RST_B) begin
      if (!RST_B) begin
         tck_s <= 3'h0;
         tms_s <= 3'h7;
         tdi_s <= 3'h7;
         trst_s <= 3'h0;
      end else begin
         tck_s <= {tck_s[1:0], TCK};
         tms_s <= {tms_s[1:0], TMS};
         tdi_s <= {tdi_s[1:0], TDI};
         trst_s <= {trst_s[1:0], TRST_B};
      end
   end

   // Edge pulses use the second and third stages; the first is never read.
   assign tck_rise = tck_s[1] & ~tck_s[2];
   assign tck_fall = ~tck_s[1] & tck_s[2];
   assign trst_low = ~trst_s[1];
   assign tms_bit = tms_s[1];

   // Standard TAP transitions; five high mode select clocks always reach reset.
   // Every code of the enum is a state, so no default item is needed.
   always_comb begin
      unique case (state)
         jbci_pkg::JBCI_RESET: next_state = tms_bit ? jbci_pkg::JBCI_RESET : jbci_pkg::JBCI_IDLE;
         jbci_pkg::JBCI_IDLE: next_state = tms_bit ? jbci_pkg::JBCI_SEL_DR : jbci_pkg::JBCI_IDLE;
         jbci_pkg::JBCI_SEL_DR: next_state = tms_bit ? jbci_pkg::JBCI_SEL_IR : jbci_pkg::JBCI_CAP_DR;
         jbci_pkg::JBCI_CAP_DR: next_state = tms_bit ? jbci_pkg::JBCI_EXIT1_DR : jbci_pkg::JBCI_SHIFT_DR;
         jbci_pkg::JBCI_SHIFT_DR: next_state = tms_bit ? jbci_pkg::JBCI_EXIT1_DR : jbci_pkg::JBCI_SHIFT_DR;
         jbci_pkg::JBCI_EXIT1_DR: next_state = tms_bit ? jbci_pkg::JBCI_UPD_DR : jbci_pkg::JBCI_PAUSE_DR;
         jbci_pkg::JBCI_PAUSE_DR: next_state = tms_bit ? jbci_pkg::JBCI_EXIT2_DR : jbci_pkg::JBCI_PAUSE_DR;
         jbci_pkg::JBCI_EXIT2_DR: next_state = tms_bit ? jbci_pkg::JBCI_UPD_DR : jbci_pkg::JBCI_SHIFT_DR;
         jbci_pkg::JBCI_UPD_DR: next_state = tms_bit ? jbci_pkg::JBCI_SEL_DR : jbci_pkg::JBCI_IDLE;
         jbci_pkg::JBCI_SEL_IR: next_state = tms_bit ? jbci_pkg::JBCI_RESET : jbci_pkg::JBCI_CAP_IR;
         jbci_pkg::JBCI_CAP_IR: next_state = tms_bit ? jbci_pkg::JBCI_EXIT1_IR : jbci_pkg::JBCI_SHIFT_IR;
         jbci_pkg::JBCI_SHIFT_IR: next_state = tms_bit ? jbci_pkg::JBCI_EXIT1_IR : jbci_pkg::JBCI_SHIFT_IR;
         jbci_pkg::JBCI_EXIT1_IR: next_state = tms_bit ? jbci_pkg::JBCI_UPD_IR : jbci_pkg::JBCI_PAUSE_IR;
         jbci_pkg::JBCI_PAUSE_IR: next_state = tms_bit ? jbci_pkg::JBCI_EXIT2_IR : jbci_pkg::JBCI_PAUSE_IR;
         jbci_pkg::JBCI_EXIT2_IR: next_state = tms_bit ? jbci_pkg::JBCI_UPD_IR : jbci_pkg::JBCI_SHIFT_IR;
         jbci_pkg::JBCI_UPD_IR: next_state = tms_bit ? jbci_pkg::JBCI_SEL_DR : jbci_pkg::JBCI_IDLE;
      endcase
   end

   // State register; the test reset pin overrides everything.
   // The high count is a safety net: an upset state still returns to reset.
   always_ff @(posedge CLK_SYS or negedge RST_B) begin
      if (!RST_B) begin
         state <= jbci_pkg::JBCI_RESET;
      end else if (trst_low) begin
         state <= jbci_pkg::JBCI_RESET;
      end else if (tck_rise) begin
         state <= next_state;
      end else if (tms_high_cnt == `JBCI_TMS_RESET_CNT) begin
         state <= jbci_pkg::JBCI_RESET;
      end
   end

   // Counts consecutive high mode select clocks as a cross-check of the walk to reset.
   // It saturates, so a tester parked in reset never wraps it back to zero.
   always_ff @(posedge CLK_SYS or negedge RST_B) begin
      if (!RST_B) begin
         tms_high_cnt <= 3'h0;
      end else if (trst_low) begin
         tms_high_cnt <= 3'h0;
      end else if (tck_rise) begin
         if (!tms_bit) begin
            tms_high_cnt <= 3'h0;
         end else if (tms_high_cnt != `JBCI_TMS_RESET_CNT) begin
            tms_high_cnt <= tms_high_cnt + 3'h1;
         end
      end
   end

   // Instruction shift path; capture pattern on Capture-IR, shift on rising edges.
   // Shifting never touches the current instruction, so outputs stay quiet.
   always_ff @(posedge CLK_SYS or negedge RST_B) begin
      if (!RST_B) begin
         ir_shift <= `JBCI_CAPTURE_IR_PATTERN;
      end else if (tck_rise) begin
         if (state == jbci_pkg::JBCI_CAP_IR) begin
            ir_shift <= `JBCI_CAPTURE_IR_PATTERN;
         end else if (state == jbci_pkg::JBCI_SHIFT_IR) begin
            ir_shift <= {tdi_s[1], ir_shift[`JBCI_IR_W-1:1]};
         end
      end
   end

   // Current instruction changes only in Update-IR; reset restores identification.
   // The update waits for the falling test clock, half a cycle after the
   // state is entered, so the shift stage has surely settled by then.
   always_ff @(posedge CLK_SYS or negedge RST_B) begin
      if (!RST_B) begin
         ir <= `JBCI_OP_IDCODE;
      end else if (trst_low || state == jbci_pkg::JBCI_RESET) begin
         ir <= `JBCI_OP_IDCODE;
      end else if (tck_fall && state == jbci_pkg::JBCI_UPD_IR) begin
         ir <= ir_shift;
      end
   end

   // Decode; any code other than identification, including reserved, picks bypass.
   // Reserved codes thus do nothing harmful if a tester loads one by mistake.
   assign sel_id = (ir == `JBCI_OP_IDCODE);
   assign sel_bypass = !sel_id;
   assign sel_clamp = (ir == `JBCI_OP_CLAMP);

   // Identification register; parallel load in Capture-DR, shift LSB first.
   // The fields are parameters, so a new revision needs no change to this logic.
   always_ff @(posedge CLK_SYS or negedge RST_B) begin
      if (!RST_B) begin
         id_shift <= {`JBCI_ID_W{1'b0}};
      end else if (tck_rise && sel_id) begin
         if (state == jbci_pkg::JBCI_CAP_DR) begin
            id_shift <= {REVISION, PART_CODE, MAKER_CODE, `JBCI_ID_LSB};
         end else if (state == jbci_pkg::JBCI_SHIFT_DR) begin
            id_shift <= {tdi_s[1], id_shift[`JBCI_ID_W-1:1]};
         end
      end
   end

   // Single bypass bit, cleared on capture.
   // A zero first bit tells the tester that this device sits in bypass.
   always_ff @(posedge CLK_SYS or negedge RST_B) begin
      if (!RST_B) begin
         bypass_bit <= `JBCI_BYPASS_CAPTURE;
      end else if (tck_rise && sel_bypass) begin
         if (state == jbci_pkg::JBCI_CAP_DR) begin
            bypass_bit <= `JBCI_BYPASS_CAPTURE;
         end else if (state == jbci_pkg::JBCI_SHIFT_DR) begin
            bypass_bit <= tdi_s[1];
         end
      end
   end

   // Serial output source for the current scan state.
   // Instruction scans win over the data register selection.
   always_comb begin
      if (state == jbci_pkg::JBCI_SHIFT_IR) begin
         shift_out = ir_shift[0];
      end else if (sel_id) begin
         shift_out = id_shift[0];
      end else begin
         shift_out = bypass_bit;
      end
   end

   // Data out changes on the falling test clock, enabled only while shifting.
   // Launching on the fall gives the tester half a test clock of setup
   // before it samples on the next rise; the sampler delay eats into that.
   always_ff @(posedge CLK_SYS or negedge RST_B) begin
      if (!RST_B) begin
         TDO <= 1'b0;
         TDO_OE <= 1'b0;
      end else if (trst_low) begin
         TDO_OE <= 1'b0;
      end else if (tck_fall) begin
         TDO <= shift_out;
         TDO_OE <= (state == jbci_pkg::JBCI_SHIFT_DR) || (state == jbci_pkg::JBCI_SHIFT_IR);
      end
   end

   // Clamp holds pins at boundary values; otherwise functional data passes.
   // Both outputs come from one decode, so the flag and the pins never
   // disagree; the price is one system clock of latency on the pins.
   always_ff @(posedge CLK_SYS or negedge RST_B) begin
      if (!RST_B) begin
         PIN_OUT <= {BSR_W{1'b0}};
         CLAMP_ACTIVE <= 1'b0;
      end else begin
         CLAMP_ACTIVE <= sel_clamp;
         PIN_OUT <= sel_clamp ? BSR_HOLD : CORE_OUT;
      end
   end
endmodule

/* tb/jbci_tap_props.sv */
// Checker for the access port outputs.
`timescale 1ns/1ps
module jbci_tap_props #(parameter int BSR_W = 8) (
   input wire logic CLK_SYS, // Clock.
   input wire logic RST_B, // Reset.
   input wire logic TCK, // Test clock.
   input wire logic TMS, // Mode select.
   input wire logic TRST_B, // Test reset.
   input wire logic [BSR_W-1:0] BSR_HOLD, // Held values.
   input wire logic [BSR_W-1:0] CORE_OUT, // Core values.
   input wire logic [BSR_W-1:0] PIN_OUT, // Pin values.
   input wire logic CLAMP_ACTIVE, // Clamp flag.
   input wire logic TDO, // Data out.
   input wire logic TDO_OE // Data out enable.
);
   logic tck_q;
   logic [2:0] tms_cnt;
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (!RST_B);
   // Counts test clock rises with mode select high; it saturates so long idles never wrap.
   always_ff @(posedge CLK_SYS or negedge RST_B) begin
      if (!RST_B) begin
         tck_q <= 1'b0;
         tms_cnt <= 3'h0;
      end else begin
         tck_q <= TCK;
         if (TCK && !tck_q) tms_cnt <= !TMS ? 3'h0 : tms_cnt + {2'h0, tms_cnt != 3'h7};
      end
   end
   sequence trst_held; !TRST_B [*5]; endsequence
   sequence tms_five; tms_cnt == 3'h5; endsequence
   a_clamp_hold: assert property (CLAMP_ACTIVE [*3] |-> PIN_OUT == $past(BSR_HOLD))
      else $error("Pins not held while clamped.");
   a_core_pass: assert property (!CLAMP_ACTIVE [*3] |-> PIN_OUT == $past(CORE_OUT))
      else $error("Pins not following the core.");
   a_rst_outs: assert property ($rose(RST_B) |-> !CLAMP_ACTIVE && !TDO_OE && PIN_OUT == '0)
      else $error("Outputs not cleared by reset.");
   a_trst_noclamp: assert property (trst_held |-> !CLAMP_ACTIVE)
      else $error("Clamp survives test reset.");
   a_trst_nooe: assert property (trst_held |-> !TDO_OE)
      else $error("Data out enabled in test reset.");
   a_tms_reset: assert property (tms_five |-> ##[1:6] (!CLAMP_ACTIVE && !TDO_OE))
      else $error("Mode select high did not reset.");
   a_tdo_still: assert property (TCK && $past(TCK) |-> $stable(TDO))
      else $error("Data out moved while test clock high.");
   a_clamp_rise: assert property ($rose(CLAMP_ACTIVE) |-> !TDO_OE && !$past(TCK, 2))
      else $error("Clamp took effect outside update.");
endmodule
bind jbci_tap jbci_tap_props #(.BSR_W(BSR_W)) jbci_tap_props_i (.CLK_SYS(CLK_SYS),
   .RST_B(RST_B), .TCK(TCK), .TMS(TMS), .TRST_B(TRST_B), .BSR_HOLD(BSR_HOLD),
   .CORE_OUT(CORE_OUT), .PIN_OUT(PIN_OUT), .CLAMP_ACTIVE(CLAMP_ACTIVE), .TDO(TDO),
   .TDO_OE(TDO_OE));

/* tb/jbci_tester.sv */
// Behavioural tester that drives the test pins.
`timescale 1ns/1ps
module jbci_tester (
   input wire logic CLK_SYS, // Clock.
   input wire logic TDO, // Data out wire.
   output logic TCK, // Test clock, still between steps.
   output logic TMS, // Mode select.
   output logic TDI, // Data in.
   output logic TRST_B // Test reset.
);
   // Rests with mode select high, as a pulled-up pin would.
   initial begin
      TCK = 1'b0;
      TMS = 1'b1;
      TDI = 1'b1;
      TRST_B = 1'b0;
   end
   // Drives the test reset pin; called at a falling system edge.
   task automatic set_trst(input logic v);
      TRST_B = v;
   endtask
   // One 160 ns test clock, entered at a falling system edge; data out is taken at the rise.
   task automatic step(input logic m, input logic d, output logic q);
      TMS = m;
      TDI = d;
      repeat (4) @(negedge CLK_SYS);
      q = TDO;
      TCK = 1'b1;
      repeat (4) @(negedge CLK_SYS);
      TCK = 1'b0;
   endtask
endmodule

/* tb/jbci_tap_bench.sv */
// Self-checking bench for the access port bypass, clamp and identification logic.
`timescale 1ns/1ps
`include "jbci_defines.svh"
module jbci_tap_bench;
   localparam logic [10:0] MK = 11'h2a5; // Arbitrary value.
   localparam logic [15:0] PT = 16'h5a3c; // Arbitrary value.
   localparam logic [3:0] RV = 4'h9; // Arbitrary value.
   logic CLK_SYS = 1'b0;
   logic RST_B = 1'b0;
   logic TCK, TMS, TDI, TRST_B, TDO, TDO_OE, CLAMP_ACTIVE, q;
   logic [7:0] BSR_HOLD = 8'ha5;
   logic [7:0] CORE_OUT = 8'h3c;
   logic [7:0] PIN_OUT;
   logic [5:0] ops [2] = '{`JBCI_OP_BYPASS, `JBCI_OP_CLAMP};
   logic [31:0] got;
   int n_mismatch = 0;
   int num_checks = 0;
   wire tdo_pin = TDO_OE ? TDO : ~TDO; // Released data out shows the inverse, so a late enable shows.
   always #10 CLK_SYS = ~CLK_SYS;
   jbci_tap #(.MAKER_CODE(MK), .PART_CODE(PT), .REVISION(RV), .BSR_W(8)) jbci_tap_i (
      .CLK_SYS(CLK_SYS), .RST_B(RST_B), .TCK(TCK), .TMS(TMS), .TDI(TDI), .TRST_B(TRST_B),
      .BSR_HOLD(BSR_HOLD), .CORE_OUT(CORE_OUT), .PIN_OUT(PIN_OUT),
      .CLAMP_ACTIVE(CLAMP_ACTIVE), .TDO(TDO), .TDO_OE(TDO_OE));
   jbci_tester jbci_tester_i (.CLK_SYS(CLK_SYS), .TDO(tdo_pin), .TCK(TCK), .TMS(TMS),
      .TDI(TDI), .TRST_B(TRST_B));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wrap_up();
      $display("Checks %0d, mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // Idle to shift, n bits LSB first, then update and back to idle.
   task automatic scan(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
      logic c0;
      c0 = CLAMP_ACTIVE;
      dout = '0;
      jbci_tester_i.step(1'b1, 1'b1, q);
      if (ir) jbci_tester_i.step(1'b1, 1'b1, q);
      jbci_tester_i.step(1'b0, 1'b1, q);
      jbci_tester_i.step(1'b0, 1'b1, q);
      for (int i = 0; i < n; i++) begin
         jbci_tester_i.step(i == n - 1, din[i], q);
         dout[i] = q;
      end
      if (ir) check(CLAMP_ACTIVE, c0);
      jbci_tester_i.step(1'b1, 1'b1, q);
      jbci_tester_i.step(1'b0, 1'b1, q);
      repeat (4) @(negedge CLK_SYS);
   endtask
   // Watchdog so that a stuck run still reaches the verdict.
   initial begin
      #400000;
      n_mismatch++;
      wrap_up();
   end
   initial begin
      repeat (2) @(negedge CLK_SYS);
      RST_B = 1'b1;
      jbci_tester_i.set_trst(1'b1);
      jbci_tester_i.step(1'b0, 1'b1, q);
      scan(1'b0, 32, 32'hffffffff, got);
      check(got, {RV, PT, MK, `JBCI_ID_LSB});
      $display("Identification test done");
      foreach (ops[k]) begin
         scan(1'b1, 6, {26'h0, ops[k]}, got);
         check(got[5:0], `JBCI_CAPTURE_IR_PATTERN);
         CORE_OUT = ~CORE_OUT;
         repeat (3) @(negedge CLK_SYS);
         check(CLAMP_ACTIVE, ops[k] == `JBCI_OP_CLAMP);
         check(PIN_OUT, (ops[k] == `JBCI_OP_CLAMP) ? BSR_HOLD : CORE_OUT);
         scan(1'b0, 3, 32'h5, got);
         check(got[2:0], 3'h2);
      end
      $display("Bypass and clamp test done");
      repeat (5) jbci_tester_i.step(1'b1, 1'b1, q);
      jbci_tester_i.step(1'b0, 1'b1, q);
      check(CLAMP_ACTIVE, 1'b0);
      scan(1'b0, 32, 32'h0, got);
      check(got, {RV, PT, MK, `JBCI_ID_LSB});
      $display("Mode select reset test done");
      scan(1'b1, 6, {26'h0, `JBCI_OP_CLAMP}, got);
      jbci_tester_i.set_trst(1'b0);
      repeat (6) @(negedge CLK_SYS);
      check(CLAMP_ACTIVE, 1'b0);
      jbci_tester_i.set_trst(1'b1);
      $display("Test reset test done");
      wrap_up();
   end
endmodule
